// >>> rtl/dcb_consts.svh
// constants for the dc braking sequencer
`ifndef DCB_CONSTS_SVH
`define DCB_CONSTS_SVH
`define DCB_SEL_OFF 2'h0
`define DCB_SEL_STARTSTOP 2'h1
`define DCB_SEL_FREQ 2'h2
`define DCB_DET_EDGE 1'h0
`define DCB_DET_LEVEL 1'h1
`define DCB_FUNC_BRAKE 8'h07
`define DCB_FORCE_MAX 8'h23
`define DCB_HYST_CHZ 16'h00c8
`define DCB_FREQ_MAX_CHZ 16'h9c40
`define DCB_WAIT_MAX_DS 16'h0032
`define DCB_TIME_MAX_DS 16'h0258
`define DCB_CAR_MIN_DKHZ 8'h05
`define DCB_CAR_MAX_DKHZ 8'h1e
`define DCB_CLK_HZ 10000000
`define DCB_TICK_MS 100
`define DCB_CLK_KHZ 10000
`endif

// >>> rtl/dcb_pkg.sv
// types for the dc braking sequencer
package dcb_pkg;
  // output stage state, gray coded along off-wait-brake-run
  typedef enum logic [1:0] {
    DCB_IDLE = 2'b00,
    DCB_WAIT = 2'b01,
    DCB_BRAKE = 2'b11,
    DCB_RUN = 2'b10
  } dcb_state_t;

  // stored parameter set
  typedef struct packed {
    logic [1:0] enable_select;
    logic [15:0] start_freq;
    logic [15:0] wait_delay;
    logic [7:0] decel_force;
    logic [15:0] decel_duration;
    logic detect_mode;
    logic [7:0] start_force;
    logic [15:0] start_duration;
    logic [7:0] carrier_freq;
  } dcb_cfg_t;
endpackage

// >>> rtl/dcb_sequencer.sv
// dc braking sequencer: decides when, how long and how hard to brake
`timescale 1ns/1ns
`include "dcb_consts.svh"
module dcb_sequencer
  import dcb_pkg::*;
#(
  parameter int TICK_CYCLES = `DCB_CLK_HZ / 1000 * `DCB_TICK_MS
) (
  input wire logic CLK,
  input wire logic RST,
  input wire dcb_cfg_t CFG,
  input wire logic [7:0] INPUT_TERMINAL_FUNCTION_SELECT,
  input wire logic BRAKE_REQUEST_INPUT,
  input wire logic FORWARD_RUN_COMMAND,
  input wire logic [15:0] COMMAND_FREQ,
  input wire logic [15:0] OUTPUT_FREQ,
  output logic OUTPUT_OFF,
  output logic BRAKING,
  output logic NORMAL_OUTPUT,
  output logic [7:0] BRAKE_CURRENT_PCT,
  output logic BRAKE_CARRIER_TICK,
  output logic [1:0] STATE
);

  // frequencies in 0.01 Hz, times in 0.1 s ticks, carrier in 0.1 kHz

  // clamp a value to a ceiling
  function automatic logic [15:0] clamp16(input logic [15:0] v,
                                          input logic [15:0] lim);
    clamp16 = (v > lim) ? lim : v;
  endfunction

  // three stage synchronisers for the two pins
  logic [2:0] db_sync;
  logic [2:0] fw_sync;
  logic db_level;
  logic fw_level;
  logic db_prev;
  logic fw_prev;

  // pins arrive asynchronously; accept change once stages 2 and 3 agree
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      db_sync <= 3'h0;
      fw_sync <= 3'h0;
    end else begin
      db_sync <= {db_sync[1:0], BRAKE_REQUEST_INPUT};
      fw_sync <= {fw_sync[1:0], FORWARD_RUN_COMMAND};
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      db_level <= 1'b0;
      fw_level <= 1'b0;
      db_prev <= 1'b0;
      fw_prev <= 1'b0;
    end else begin
      if (db_sync[1] == db_sync[2]) begin
        db_level <= db_sync[2];
      end
      if (fw_sync[1] == fw_sync[2]) begin
        fw_level <= fw_sync[2];
      end
      db_prev <= db_level;
      fw_prev <= fw_level;
    end
  end

  // decoded settings
  logic sel_auto;
  logic sel_freq;
  logic level_mode;
  logic ext_enabled;
  logic db_rise;
  logic fw_rise;
  logic fw_fall;
  logic [15:0] start_freq;
  logic [15:0] hyst_freq;
  logic freq_low;
  logic cmd_low;
  logic cmd_high;

  assign sel_auto = CFG.enable_select == `DCB_SEL_STARTSTOP;
  assign sel_freq = CFG.enable_select == `DCB_SEL_FREQ;
  assign level_mode = CFG.detect_mode == `DCB_DET_LEVEL;
  // terminal acts only when assigned, and never in freq mode
  assign ext_enabled = (INPUT_TERMINAL_FUNCTION_SELECT == `DCB_FUNC_BRAKE)
                       && !sel_freq;
  assign db_rise = db_level && !db_prev && ext_enabled;
  assign fw_rise = fw_level && !fw_prev;
  assign fw_fall = !fw_level && fw_prev;
  assign start_freq = clamp16(CFG.start_freq, `DCB_FREQ_MAX_CHZ);
  // saturating add keeps hysteresis sane near the top of range
  assign hyst_freq = (start_freq > 16'hffff - `DCB_HYST_CHZ) ? 16'hffff
                     : 16'(start_freq + `DCB_HYST_CHZ);
  assign freq_low = OUTPUT_FREQ <= start_freq;
  assign cmd_low = COMMAND_FREQ <= start_freq;
  assign cmd_high = COMMAND_FREQ >= hyst_freq;

  // 0.1 s time base
  logic [31:0] tick_cnt;
  logic tick;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      tick_cnt <= 32'h0000_0000;
      tick <= 1'b0;
    end else if (tick_cnt >= 32'(TICK_CYCLES - 1)) begin
      tick_cnt <= 32'h0000_0000;
      tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 32'h0000_0001;
      tick <= 1'b0;
    end
  end

  // sequencer
  dcb_state_t state;
  dcb_state_t next_state;
  logic [15:0] timer;
  logic [15:0] next_timer;
  logic start_phase;
  logic next_start_phase;
  logic ext_phase;
  logic next_ext_phase;
  logic stop_pending;
  logic next_stop_pending;
  logic [15:0] wait_len;
  logic [15:0] decel_len;
  logic [15:0] start_len;
  logic timer_done;

  assign wait_len = clamp16(CFG.wait_delay, `DCB_WAIT_MAX_DS);
  assign decel_len = clamp16(CFG.decel_duration, `DCB_TIME_MAX_DS);
  assign start_len = clamp16(CFG.start_duration, `DCB_TIME_MAX_DS);
  assign timer_done = (timer == 16'h0000);

  // stop and terminal entry to braking honour the wait delay first; start and freq mode braking enter directly
  always_comb begin
    next_state = state;
    next_timer = (tick && !timer_done) ? timer - 16'h0001 : timer;
    next_start_phase = start_phase;
    next_ext_phase = ext_phase;
    next_stop_pending = stop_pending;
    if (fw_fall && sel_auto) begin
      next_stop_pending = 1'b1;
    end
    if (fw_rise) begin
      next_stop_pending = 1'b0;
    end
    case (state)
      DCB_IDLE, DCB_RUN: begin
        if (sel_freq) begin
          if (fw_level && cmd_low && freq_low) begin
            next_state = DCB_BRAKE;
            next_ext_phase = 1'b0;
            next_start_phase = 1'b0;
          end else begin
            next_state = fw_level ? DCB_RUN : DCB_IDLE;
          end
        end else if (db_rise || (ext_enabled && level_mode && db_level)) begin
          next_state = timer_done && wait_len == 16'h0000 ? DCB_BRAKE
                       : DCB_WAIT;
          next_timer = wait_len;
          next_ext_phase = 1'b1;
          next_start_phase = 1'b0;
        end else if (sel_auto && fw_rise) begin
          next_state = DCB_BRAKE;
          next_timer = start_len;
          next_start_phase = 1'b1;
          next_ext_phase = 1'b0;
        end else if (sel_auto && (stop_pending || fw_fall) && freq_low) begin
          next_state = wait_len == 16'h0000 ? DCB_BRAKE : DCB_WAIT;
          next_timer = wait_len;
          next_stop_pending = 1'b0;
          next_start_phase = 1'b0;
          next_ext_phase = 1'b0;
        end else begin
          next_state = fw_level ? DCB_RUN : DCB_IDLE;
        end
      end
      DCB_WAIT: begin
        // coast with output off, then brake for decel time
        if (timer_done) begin
          next_state = DCB_BRAKE;
          next_timer = decel_len;
        end
        if (level_mode && fw_rise && !ext_phase) begin
          next_state = DCB_RUN;
        end
      end
      DCB_BRAKE: begin
        if (sel_freq) begin
          // freq mode release: level follows command, edge needs hysteresis
          if (!fw_level) begin
            next_state = DCB_IDLE;
          end else if (cmd_high || (level_mode && !cmd_low)) begin
            next_state = DCB_RUN;
          end
        end else if (ext_phase && level_mode) begin
          // terminal level governs, timer ignored
          if (!db_level) begin
            next_state = fw_level ? DCB_RUN : DCB_IDLE;
          end
        end else if (level_mode && fw_rise) begin
          next_state = DCB_RUN;
          next_start_phase = 1'b0;
        end else if (timer_done) begin
          // edge mode ignores new commands until time elapses
          next_state = fw_level ? DCB_RUN : DCB_IDLE;
          next_start_phase = 1'b0;
        end
      end
      default: begin
        next_state = DCB_IDLE;
      end
    endcase
  end

  // brake entry from a zero-length wait must still load decel time
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state <= DCB_IDLE;
      timer <= 16'h0000;
      start_phase <= 1'b0;
      ext_phase <= 1'b0;
      stop_pending <= 1'b0;
    end else begin
      state <= next_state;
      start_phase <= next_start_phase;
      ext_phase <= next_ext_phase;
      stop_pending <= next_stop_pending;
      if (next_state == DCB_BRAKE && state != DCB_BRAKE
          && state != DCB_WAIT && !next_start_phase) begin
        timer <= decel_len;
      end else begin
        timer <= next_timer;
      end
    end
  end

  // braking carrier: half period in cycles from 0.1 kHz setting
  logic [7:0] car_set;
  logic [15:0] car_cnt;
  logic [15:0] car_half;

  assign car_set = (CFG.carrier_freq < `DCB_CAR_MIN_DKHZ) ? `DCB_CAR_MIN_DKHZ
                 : (CFG.carrier_freq > `DCB_CAR_MAX_DKHZ) ? `DCB_CAR_MAX_DKHZ
                 : CFG.carrier_freq;
  assign car_half = 16'(32'(`DCB_CLK_KHZ * 10) / (32'(car_set) * 32'd2));

  // carrier only runs while braking, so no switching when idle
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      car_cnt <= 16'h0000;
      BRAKE_CARRIER_TICK <= 1'b0;
    end else if (state != DCB_BRAKE) begin
      car_cnt <= 16'h0000;
      BRAKE_CARRIER_TICK <= 1'b0;
    end else if (car_cnt >= car_half - 16'h0001) begin
      car_cnt <= 16'h0000;
      BRAKE_CARRIER_TICK <= 1'b1;
    end else begin
      car_cnt <= car_cnt + 16'h0001;
      BRAKE_CARRIER_TICK <= 1'b0;
    end
  end

  // registered outputs
  logic [7:0] force_sel;
  assign force_sel = (next_start_phase ? CFG.start_force
                      : CFG.decel_force);
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      OUTPUT_OFF <= 1'b1;
      BRAKING <= 1'b0;
      NORMAL_OUTPUT <= 1'b0;
      BRAKE_CURRENT_PCT <= 8'h00;
      STATE <= 2'h0;
    end else begin
      OUTPUT_OFF <= next_state == DCB_IDLE || next_state == DCB_WAIT;
      BRAKING <= next_state == DCB_BRAKE;
      NORMAL_OUTPUT <= next_state == DCB_RUN;
      BRAKE_CURRENT_PCT <= next_state != DCB_BRAKE ? 8'h00
                         : (force_sel > `DCB_FORCE_MAX ? `DCB_FORCE_MAX
                            : force_sel);
      STATE <= next_state;
    end
  end

endmodule

// >>> tb/dcb_seq_asserts.sv
// port assertions for the dc braking sequencer
`timescale 1ns/1ns
module dcb_seq_asserts
  import dcb_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire dcb_cfg_t CFG,
  input wire logic [7:0] INPUT_TERMINAL_FUNCTION_SELECT,
  input wire logic FORWARD_RUN_COMMAND,
  input wire logic OUTPUT_OFF,
  input wire logic BRAKING,
  input wire logic NORMAL_OUTPUT,
  input wire logic [7:0] BRAKE_CURRENT_PCT,
  input wire logic BRAKE_CARRIER_TICK,
  input wire logic [1:0] STATE
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);
  // eight cycles outlasts the pin synchroniser
  sequence s_freq_idle;
    (CFG.enable_select == 2'h2 && !FORWARD_RUN_COMMAND) [*8];
  endsequence
  sequence s_no_source;
    (CFG.enable_select == 2'h0
     && INPUT_TERMINAL_FUNCTION_SELECT != 8'h07) [*8];
  endsequence
  a_off_state: assert property (
    OUTPUT_OFF == (STATE inside {DCB_IDLE, DCB_WAIT}))
    else $error("output off flag disagrees with state");
  a_brake_state: assert property (
    BRAKING == (STATE == DCB_BRAKE))
    else $error("braking flag disagrees with state");
  a_run_state: assert property (
    NORMAL_OUTPUT == (STATE == DCB_RUN))
    else $error("normal flag disagrees with state");
  a_pct_idle: assert property (
    !BRAKING |-> BRAKE_CURRENT_PCT == 8'h00)
    else $error("current while not braking");
  a_pct_force: assert property (
    BRAKING |-> BRAKE_CURRENT_PCT == CFG.decel_force ||
      BRAKE_CURRENT_PCT == CFG.start_force)
    else $error("braking current not a force setting");
  a_tick_brake: assert property (
    BRAKE_CARRIER_TICK |-> BRAKING || $past(BRAKING))
    else $error("carrier tick outside braking");
  a_tick_pulse: assert property (
    BRAKE_CARRIER_TICK |=> !BRAKE_CARRIER_TICK)
    else $error("carrier tick longer than a cycle");
  a_freq_stop: assert property (
    s_freq_idle |-> !BRAKING)
    else $error("freq mode braking without run");
  a_sel_off: assert property (
    s_no_source |-> !BRAKING)
    else $error("braking with no source enabled");
  a_pct_cap: assert property (
    BRAKE_CURRENT_PCT <= 8'h23)
    else $error("braking current above ceiling");
  a_wait_exit: assert property (
    STATE == DCB_WAIT |=> STATE != DCB_IDLE)
    else $error("wait ended without braking");
endmodule

// >>> tb/dcb_motor_model.sv
// motor and power stage model: speed follows drive, coasts when off
`timescale 1ns/1ns
module dcb_motor_model #(
  parameter logic [15:0] STEP = 16'h0032
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic normal,
  input wire logic [15:0] cmd_freq,
  output logic [15:0] out_freq
);
  // fixed ramp step keeps the stop point predictable
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      out_freq <= 16'h0000;
    else if (normal && out_freq + STEP <= cmd_freq)
      out_freq <= out_freq + STEP;
    else if (normal && out_freq > cmd_freq + STEP)
      out_freq <= out_freq - STEP;
    else if (normal)
      out_freq <= cmd_freq;
    else if (out_freq > STEP)
      out_freq <= out_freq - STEP;
    else
      out_freq <= 16'h0000;
  end
endmodule

// >>> tb/test_dcb_sequencer.sv
// self-checking bench for the dc braking sequencer
`timescale 1ns/1ns
module test_dcb_sequencer
  import dcb_pkg::*;
;
  localparam int TK = 10;
  localparam int SL = TK + 2;
  logic clk, rst, brk_in, fw, off, brk, norm, tick;
  dcb_cfg_t cfg;
  logic [7:0] func, pct;
  logic [15:0] cmd, ofreq;
  logic [1:0] st;
  logic [31:0] sd, dd, wd, sf, df;
  int errors, cmp_count, cycles, n;
  dcb_sequencer #(.TICK_CYCLES(TK)) dut_u (.CLK(clk), .RST(rst), .CFG(cfg),
    .INPUT_TERMINAL_FUNCTION_SELECT(func), .BRAKE_REQUEST_INPUT(brk_in),
    .FORWARD_RUN_COMMAND(fw), .COMMAND_FREQ(cmd), .OUTPUT_FREQ(ofreq),
    .OUTPUT_OFF(off), .BRAKING(brk), .NORMAL_OUTPUT(norm),
    .BRAKE_CURRENT_PCT(pct), .BRAKE_CARRIER_TICK(tick), .STATE(st));
  dcb_motor_model motor_u (.clk(clk), .rst(rst), .normal(norm),
    .cmd_freq(cmd), .out_freq(ofreq));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // hang guard, well above the longest run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      test_done();
    end
  end
  task automatic test_done();
    if (errors == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #10;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  // one tick and two cycles of slack: the timer only resolves whole ticks
  function automatic logic near(input int seen, input logic [31:0] t);
    return seen + SL >= t * TK && seen <= t * TK + SL;
  endfunction
  task automatic do_rst(input int k);
    rst = 1'b1;
    fw = 1'b0;
    brk_in = 1'b0;
    cyc(k);
    rst = 1'b0;
    cyc(2);
  endtask
  task automatic rand_cfg(input logic [1:0] sel, input logic mode);
    sf = $urandom_range(35);
    df = $urandom_range(35);
    sd = $urandom_range(4, 1);
    dd = $urandom_range(5, 3);
    wd = $urandom_range(2);
    cfg = '{sel, 16'h01f4, wd[15:0], df[7:0], dd[15:0], mode, sf[7:0],
      sd[15:0], 8'h1e};
  endtask
  // length of a braking run; raises run after at cycles if at >= 0
  task automatic brk_len(input int at);
    n = 0;
    while (brk === 1'b1 && n < 8000) begin
      if (n == at) fw = 1'b1;
      cyc(1);
      n++;
    end
  endtask
  initial begin
    void'($urandom(17981));
    func = 8'h00;
    cmd = 16'h03e8;
    // automatic start and stop braking in both detect modes
    for (int i = 0; i < 4; i++) begin
      rand_cfg(2'h1, i[0]);
      do_rst(i == 0 ? 16 : 2);
      fw = 1'b1;
      repeat (20) if (brk !== 1'b1) cyc(1);
      chk("start force", pct, sf);
      brk_len(-1);
      chk("start time", near(n, sd), 1);
      cyc(2);
      chk("run after start", norm, 1);
      cyc(30);
      fw = 1'b0;
      // output is off while coasting down, so wait for wait or brake
      repeat (100) if (st === DCB_RUN || st === DCB_IDLE) cyc(1);
      chk("stop freq", ofreq <= 16'h01f4, 1);
      chk("wait off", off, wd != 0);
      n = 0;
      while (st === DCB_WAIT && n < 100) begin
        cyc(1);
        n++;
      end
      chk("wait time", near(n, wd), 1);
      chk("decel force", pct, df);
      brk_len(5);
      chk("decel time", i[0] ? n < 14 : near(n, dd), 1);
    end
    // external terminal, level then edge, then a refused function code
    rand_cfg(2'h0, 1'b1);
    cfg.wait_delay = 16'h0000;
    func = 8'h07;
    do_rst(2);
    fw = 1'b1;
    cyc(40);
    fw = 1'b0;
    cyc(25);
    chk("no auto brake", brk, 0);
    brk_in = 1'b1;
    repeat (20) if (brk !== 1'b1) cyc(1);
    chk("ext force", pct, df);
    repeat (3000) if (tick !== 1'b1) cyc(1);
    cyc(1);
    n = 1;
    while (tick !== 1'b1 && n < 3000) begin
      cyc(1);
      n++;
    end
    chk("carrier", n >= 1665 && n <= 1668, 1);
    chk("ext hold", brk, 1);
    brk_in = 1'b0;
    repeat (10) if (brk !== 1'b0) cyc(1);
    chk("ext release", brk, 0);
    cfg.detect_mode = 1'b0;
    do_rst(2);
    brk_in = 1'b1;
    cyc(6);
    brk_in = 1'b0;
    repeat (20) if (brk !== 1'b1) cyc(1);
    brk_len(-1);
    chk("ext edge time", near(n, dd), 1);
    func = 8'h06;
    brk_in = 1'b1;
    cyc(20);
    chk("func refused", brk, 0);
    // frequency triggered mode with its hysteresis
    for (int m = 0; m < 2; m++) begin
      rand_cfg(2'h2, m[0]);
      cfg.decel_duration = 16'h0258;
      func = 8'h07;
      cmd = 16'h0000;
      do_rst(2);
      fw = 1'b1;
      repeat (20) if (brk !== 1'b1) cyc(1);
      chk("zero start", brk, 1);
      cmd = 16'h0258;
      cyc(20);
      chk("hysteresis", brk, m == 0);
      cmd = 16'h02bc;
      repeat (20) if (brk !== 1'b0) cyc(1);
      chk("release", norm, 1);
      cyc(20);
      cmd = 16'h012c;
      repeat (40) if (brk !== 1'b1) cyc(1);
      chk("both low", brk, 1);
      chk("out low", ofreq <= 16'h01f4, 1);
      fw = 1'b0;
      repeat (20) if (brk !== 1'b0) cyc(1);
      chk("run off", brk, 0);
    end
    cmd = 16'h03e8;
    do_rst(2);
    fw = 1'b1;
    cyc(10);
    chk("high start", norm, 1);
    brk_in = 1'b1;
    cyc(20);
    chk("ext in freq", brk, 0);
    test_done();
  end
endmodule
bind dcb_sequencer dcb_seq_asserts chk_u (.CLK(CLK), .RST(RST), .CFG(CFG),
  .INPUT_TERMINAL_FUNCTION_SELECT(INPUT_TERMINAL_FUNCTION_SELECT),
  .FORWARD_RUN_COMMAND(FORWARD_RUN_COMMAND), .OUTPUT_OFF(OUTPUT_OFF),
  .BRAKING(BRAKING), .NORMAL_OUTPUT(NORMAL_OUTPUT),
  .BRAKE_CURRENT_PCT(BRAKE_CURRENT_PCT),
  .BRAKE_CARRIER_TICK(BRAKE_CARRIER_TICK), .STATE(STATE));
